// [hw/pmac_pkg.sv]
// Shared constants and types of the power monitor and alert one block.
package pmac_pkg;

    // ********************************************************
    // Command codes and reset values
    // ********************************************************
    localparam logic [7:0] PMAC_CMD_RUN = 8'hd3;
    localparam logic [7:0] PMAC_CMD_SETUP = 8'hd4;
    localparam logic [7:0] PMAC_CMD_ALERT = 8'hd5;
    localparam logic [7:0] PMAC_RUN_RST = 8'h00;
    localparam logic [7:0] PMAC_SETUP_RST = 8'h2c;
    localparam logic [15:0] PMAC_ALERT_RST = 16'h0000;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int PMAC_GO_BIT = 0;
    localparam int PMAC_MODE_BIT = 7;
    localparam int PMAC_SRC_BIT = 6;
    localparam int PMAC_SPAN_BIT = 5;
    localparam int PMAC_RSVD_ZERO_BIT = 4;
    localparam int PMAC_SENSE_BIT = 3;
    localparam int PMAC_AVG_MSB = 2;
    localparam int PMAC_AVG_LSB = 0;
    localparam int PMAC_POL_BIT = 3;
    localparam int PMAC_CONV_BIT = 2;
    localparam int PMAC_GPO_EN_BIT = 1;
    localparam int PMAC_GPO_DATA_BIT = 0;
    localparam logic [15:0] PMAC_ALERT_SRC_MASK = 16'hfff0;
    localparam logic [7:0] PMAC_CNT_ONE = 8'h01;

    // ********************************************************
    // State encodings
    // ********************************************************
    typedef enum logic {
        PMAC_SMP_IDLE = 1'b0,
        PMAC_SMP_BUSY = 1'b1
    } pmac_smp_t;

    typedef enum logic [2:0] {
        PMAC_H_IDLE = 3'h0,
        PMAC_H_PROBE = 3'h1,
        PMAC_H_PWAIT = 3'h3,
        PMAC_H_ISSUE = 3'h2,
        PMAC_H_WAIT = 3'h6
    } pmac_host_st_t;

endpackage

// [hw/pmac_link_if.sv]
// Command link between the management host and the monitor device.
`timescale 1ns/10ps
`default_nettype none
interface pmac_link_if;
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_code;
    logic [15:0] cmd_data;
    logic rsp_valid;
    logic rsp_nack;
    logic [15:0] rsp_data;

    modport host (
        output cmd_valid,
        output cmd_write,
        output cmd_code,
        output cmd_data,
        input rsp_valid,
        input rsp_nack,
        input rsp_data
    );

    modport dev (
        input cmd_valid,
        input cmd_write,
        input cmd_code,
        input cmd_data,
        output rsp_valid,
        output rsp_nack,
        output rsp_data
    );
endinterface
`default_nettype wire

// [hw/pmac_device.sv]
// Device end: monitor run control, sampling setup and alert one pin.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Control reads zero after reset; idle while go low.
// - Writing go bit one starts current and voltage sampling.
// - Single-shot clears go after one averaged cycle.
// - Continuous keeps go high; host writes zero to stop.
// - Control bits seven to one read zero.
// - Setup byte is read/write, resets to 0x2c.
// - Host stops monitor before changing any setting; pmac_host refuses a setup or alert write while go reads high instead.
// - Setup bit seven picks single-shot or continuous.
// - Setup bit six picks input or output voltage.
// - Without output voltage pin host writes bit six zero.
// - Setup bit five picks low or high span.
// - Host writes reserved setup bit four as zero.
// - Host keeps setup bit three at one.
// - Averaging field selects one to 128 samples.
// - Alert enables word is read/write, resets zero.
// - Enabled status bit asserts alert; disabled bit never does.
// - Fault enables sit in bits fifteen to eleven.
// - Warning enables sit in bits ten to six.
// - Variant lacking pin one refuses the alert command.
// - Alert bit three sets the alert output polarity.
// - Alert bit two makes pin one a convert input.

module pmac_device
    import pmac_pkg::*;
#(
    parameter logic HAS_PIN_ONE = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    pmac_link_if.dev link,
    input wire logic [15:0] status,
    input wire logic adc_done,
    output logic adc_start,
    output logic cycle_done,
    output logic monitor_running,
    output logic sampling_mode_select,
    output logic voltage_source_select,
    output logic voltage_span_select,
    output logic [2:0] avg_code,
    input wire logic pin_one_in,
    output logic pin_one_out,
    output logic pin_one_oe
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic go;
        logic [7:0] setup;
        logic [15:0] alert;
        pmac_smp_t smp;
        logic [7:0] cnt;
        logic [2:0] sync;
        logic lvl;
        logic start;
        logic done;
        logic pin_out;
        logic pin_oe;
        logic rsp_valid;
        logic rsp_nack;
        logic [15:0] rsp_data;
    } pmac_dev_t;

    localparam pmac_dev_t DEV_RST = '{
        go: PMAC_RUN_RST[PMAC_GO_BIT],
        setup: PMAC_SETUP_RST,
        alert: PMAC_ALERT_RST,
        smp: PMAC_SMP_IDLE,
        cnt: 8'h00,
        sync: 3'h0,
        lvl: 1'b0,
        start: 1'b0,
        done: 1'b0,
        pin_out: 1'b1,
        pin_oe: 1'b0,
        rsp_valid: 1'b0,
        rsp_nack: 1'b0,
        rsp_data: 16'h0000
    };

    pmac_dev_t st_q;
    pmac_dev_t st_d;
    logic conv_mode;
    logic trig;
    logic active;
    logic level;
    logic [7:0] last;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_d = st_q;
        st_d.start = 1'b0;
        st_d.done = 1'b0;
        st_d.rsp_valid = 1'b0;

        // Only the filtered level feeds the edge detector, so a
        // slow or noisy edge on pin one triggers a single cycle.
        st_d.sync = {st_q.sync[1:0], pin_one_in};
        if (st_q.sync[1] == st_q.sync[2]) begin
            st_d.lvl = st_q.sync[2];
        end
        conv_mode = HAS_PIN_ONE && st_q.alert[PMAC_CONV_BIT];
        trig = conv_mode && st_q.sync[1] && st_q.sync[2] && !st_q.lvl;

        last = (PMAC_CNT_ONE << st_q.setup[PMAC_AVG_MSB:PMAC_AVG_LSB])
            - PMAC_CNT_ONE;

        unique case (st_q.smp)
            PMAC_SMP_IDLE: begin
                st_d.cnt = 8'h00;
                if (st_q.go) begin
                    st_d.start = 1'b1;
                    st_d.smp = PMAC_SMP_BUSY;
                end
            end
            PMAC_SMP_BUSY: begin
                if (!st_q.go) begin
                    st_d.smp = PMAC_SMP_IDLE;
                    st_d.cnt = 8'h00;
                end else if (adc_done) begin
                    if (st_q.cnt == last) begin
                        st_d.done = 1'b1;
                        st_d.cnt = 8'h00;
                        if (st_q.setup[PMAC_MODE_BIT]) begin
                            st_d.start = 1'b1;
                        end else begin
                            st_d.smp = PMAC_SMP_IDLE;
                            st_d.go = 1'b0;
                        end
                    end else begin
                        st_d.cnt = st_q.cnt + PMAC_CNT_ONE;
                        st_d.start = 1'b1;
                    end
                end
            end
        endcase

        if (trig) begin
            st_d.go = 1'b1;
        end

        // ****************************************************
        // Command decode
        // ****************************************************
        if (link.cmd_valid) begin
            st_d.rsp_valid = 1'b1;
            st_d.rsp_nack = 1'b0;
            st_d.rsp_data = 16'h0000;
            unique case (link.cmd_code)
                PMAC_CMD_RUN: begin
                    if (link.cmd_write) begin
                        // A host write lands after the self-clear, so
                        // a restart in the finishing cycle is kept.
                        st_d.go = link.cmd_data[PMAC_GO_BIT];
                    end else begin
                        st_d.rsp_data[PMAC_GO_BIT] = st_q.go;
                    end
                end
                PMAC_CMD_SETUP: begin
                    if (link.cmd_write) begin
                        st_d.setup = link.cmd_data[7:0];
                    end else begin
                        st_d.rsp_data[7:0] = st_q.setup;
                    end
                end
                PMAC_CMD_ALERT: begin
                    if (!HAS_PIN_ONE) begin
                        st_d.rsp_nack = 1'b1;
                    end else if (link.cmd_write) begin
                        st_d.alert = link.cmd_data;
                    end else begin
                        st_d.rsp_data = st_q.alert;
                    end
                end
                default: begin
                    st_d.rsp_nack = 1'b1;
                end
            endcase
        end

        // ****************************************************
        // Alert one pin
        // ****************************************************
        active = |(status & st_q.alert & PMAC_ALERT_SRC_MASK);
        if (st_q.alert[PMAC_POL_BIT]) begin
            level = active;
        end else begin
            level = !active;
        end
        if (st_q.alert[PMAC_GPO_EN_BIT]) begin
            level = st_q.alert[PMAC_GPO_DATA_BIT];
        end
        st_d.pin_out = level;
        st_d.pin_oe = HAS_PIN_ONE && !conv_mode;
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q <= DEV_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Setup fields are passed on unchanged; keeping the reserved
    // and source bits right is the host's duty.
    assign adc_start = st_q.start;
    assign cycle_done = st_q.done;
    assign monitor_running = st_q.go;
    assign sampling_mode_select = st_q.setup[PMAC_MODE_BIT];
    assign voltage_source_select = st_q.setup[PMAC_SRC_BIT];
    assign voltage_span_select = st_q.setup[PMAC_SPAN_BIT];
    assign avg_code = st_q.setup[PMAC_AVG_MSB:PMAC_AVG_LSB];
    assign pin_one_out = st_q.pin_out;
    assign pin_one_oe = st_q.pin_oe;
    assign link.rsp_valid = st_q.rsp_valid;
    assign link.rsp_nack = st_q.rsp_nack;
    assign link.rsp_data = st_q.rsp_data;

endmodule
`default_nettype wire

// [hw/pmac_host.sv]
// Host end: issues commands and guards the monitor settings.
`timescale 1ns/10ps
`default_nettype none
module pmac_host
    import pmac_pkg::*;
#(
    parameter logic HAS_OUTPUT_VOLTAGE_PIN_PIN = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    pmac_link_if.host link,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_code,
    input wire logic [15:0] req_data,
    output logic req_ready,
    output logic done,
    output logic [15:0] rdata,
    output logic nack,
    output logic refused
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        pmac_host_st_t st;
        logic [7:0] code;
        logic cmd_valid;
        logic cmd_write;
        logic [7:0] cmd_code;
        logic [15:0] cmd_data;
        logic ready;
        logic done;
        logic [15:0] rdata;
        logic nack;
        logic refused;
    } pmac_host_t;

    pmac_host_t st_q;
    pmac_host_t st_d;
    logic guarded;
    logic [15:0] clean;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_d = st_q;
        st_d.cmd_valid = 1'b0;
        st_d.done = 1'b0;
        st_d.refused = 1'b0;
        guarded = req_write && (req_code == PMAC_CMD_SETUP
            || req_code == PMAC_CMD_ALERT);
        clean = req_data;
        if (req_code == PMAC_CMD_SETUP) begin
            clean[PMAC_RSVD_ZERO_BIT] = 1'b0;
            clean[PMAC_SENSE_BIT] = 1'b1;
            clean[PMAC_SRC_BIT] = req_data[PMAC_SRC_BIT]
                && HAS_OUTPUT_VOLTAGE_PIN_PIN;
        end
        unique case (st_q.st)
            PMAC_H_IDLE: begin
                if (req_valid && st_q.ready) begin
                    st_d.code = req_code;
                    st_d.cmd_valid = 1'b1;
                    st_d.cmd_code = req_code;
                    st_d.cmd_data = clean;
                    if (guarded) begin
                        // Read the run state first; a setting is written only
                        // if go read low at the probe.
                        st_d.cmd_write = 1'b0;
                        st_d.cmd_code = PMAC_CMD_RUN;
                        st_d.st = PMAC_H_PROBE;
                    end else begin
                        // Run writes pass as given, so stopping
                        // continuous sampling is a plain write.
                        st_d.cmd_write = req_write;
                        st_d.st = PMAC_H_ISSUE;
                    end
                end
            end
            PMAC_H_PROBE: begin
                st_d.st = PMAC_H_PWAIT;
            end
            PMAC_H_PWAIT: begin
                if (link.rsp_valid) begin
                    if (link.rsp_data[PMAC_GO_BIT]) begin
                        st_d.refused = 1'b1;
                        st_d.done = 1'b1;
                        st_d.nack = 1'b0;
                        st_d.rdata = 16'h0000;
                        st_d.st = PMAC_H_IDLE;
                    end else begin
                        st_d.cmd_valid = 1'b1;
                        st_d.cmd_write = 1'b1;
                        st_d.st = PMAC_H_ISSUE;
                        // The held code picks the setting; the data has
                        // stood unchanged on the link since the probe.
                        st_d.cmd_code = st_q.code;
                    end
                end
            end
            PMAC_H_ISSUE: begin
                st_d.st = PMAC_H_WAIT;
            end
            PMAC_H_WAIT: begin
                if (link.rsp_valid) begin
                    st_d.done = 1'b1;
                    st_d.rdata = link.rsp_data;
                    st_d.nack = link.rsp_nack;
                    st_d.st = PMAC_H_IDLE;
                end
            end
            default: begin
                st_d.st = PMAC_H_IDLE;
            end
        endcase
        st_d.ready = (st_d.st == PMAC_H_IDLE);
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.cmd_valid = st_q.cmd_valid;
    assign link.cmd_write = st_q.cmd_write;
    assign link.cmd_code = st_q.cmd_code;
    assign link.cmd_data = st_q.cmd_data;
    assign req_ready = st_q.ready;
    assign done = st_q.done;
    assign rdata = st_q.rdata;
    assign nack = st_q.nack;
    assign refused = st_q.refused;

endmodule
`default_nettype wire

// [dv/pmac_link_props.sv]
// Concurrent checks on the command link between host and device ends.
`timescale 1ns/10ps
`default_nettype none
module pmac_link_props
    import pmac_pkg::*;
#(
    parameter logic HAS_PIN_ONE = 1'b1,
    parameter logic HAS_OUTPUT_VOLTAGE_PIN_PIN = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic rsp_nack,
    input wire logic [15:0] rsp_data
);
    // ********************************************************
    // Shadows of what the host last wrote
    // ********************************************************
    // The go shadow ignores the pin convert input, so the bench must not
    // read the run byte while a pin-started cycle is still going.
    logic [7:0] setup_q;
    logic [15:0] alert_q;
    logic go_set_q;
    logic rd_run;
    logic rd_setup;
    logic wr_guard;
    assign rd_run = cmd_valid && !cmd_write && cmd_code == PMAC_CMD_RUN;
    assign rd_setup = cmd_valid && !cmd_write && cmd_code == PMAC_CMD_SETUP;
    assign wr_guard = cmd_valid && cmd_write
        && (cmd_code == PMAC_CMD_SETUP || cmd_code == PMAC_CMD_ALERT);
    always_ff @(posedge clock) begin
        if (!resetn) begin
            setup_q <= PMAC_SETUP_RST;
            alert_q <= PMAC_ALERT_RST;
            go_set_q <= 1'b0;
        end else if (cmd_valid && cmd_write) begin
            if (cmd_code == PMAC_CMD_SETUP) setup_q <= cmd_data[7:0];
            if (cmd_code == PMAC_CMD_ALERT) alert_q <= cmd_data;
            if (cmd_code == PMAC_CMD_RUN) go_set_q <= cmd_data[0];
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    AST_RUN_RSVD: assert property (rd_run |=> rsp_valid && !rsp_nack
        && rsp_data[15:1] == 15'h0000) else $error("run byte upper bits set");
    AST_RUN_IDLE: assert property (rd_run && !go_set_q
        |=> rsp_data == 16'h0000) else $error("go bit set while stopped");
    AST_SETUP_RB: assert property (rd_setup |=> rsp_valid
        && rsp_data == {8'h00, $past(setup_q)}) else $error("setup readback");
    AST_ALERT_RB: assert property (cmd_valid && !cmd_write && HAS_PIN_ONE
        && cmd_code == PMAC_CMD_ALERT |=> rsp_data == $past(alert_q))
        else $error("alert enables readback");
    AST_ALERT_NACK: assert property (cmd_valid
        && cmd_code == PMAC_CMD_ALERT |=> rsp_valid && rsp_nack == !HAS_PIN_ONE)
        else $error("alert command support wrong");
    AST_GUARD: assert property (wr_guard |-> $past(rsp_valid)
        && ($past(rsp_data) & 16'h0001) == 16'h0000)
        else $error("setting written without a stopped check");
    AST_SANITISE: assert property (wr_guard && cmd_code == PMAC_CMD_SETUP
        |-> !cmd_data[4] && cmd_data[3] && (HAS_OUTPUT_VOLTAGE_PIN_PIN || !cmd_data[6]))
        else $error("setup write carries bad fixed bits");
    AST_WRITE_ACK: assert property (wr_guard
        |=> rsp_valid && !rsp_nack && rsp_data == 16'h0000)
        else $error("setting write not acknowledged");
    COV_GO: cover property (cmd_valid && cmd_write && cmd_code == PMAC_CMD_RUN
        && cmd_data[0]);
    COV_SETUP_WR: cover property (wr_guard && cmd_code == PMAC_CMD_SETUP);
    COV_ALERT_RD: cover property (cmd_valid && !cmd_write
        && cmd_code == PMAC_CMD_ALERT);
endmodule
`default_nettype wire

// [dv/power_monitor_alert_config_tb.sv]
// Self-checking bench joining the host and device ends over the link.
`timescale 1ns/10ps
`default_nettype none
module power_monitor_alert_config_tb
    import pmac_pkg::*;
;
    logic clock = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [7:0] req_code = 8'h00;
    logic [15:0] req_data = 16'h0000, status = 16'h0000, rdata;
    logic adc_done = 1'b0, pin_one_in = 1'b0, req_ready, done, nack;
    logic refused, adc_start, cycle_done, monitor_running, pin_one_out;
    logic pin_one_oe, mode_sel, src_sel, span_sel;
    logic [2:0] avg_code;
    int errors = 0, cmp_count = 0, starts = 0, cycles = 0, ticks = 0;
    int s0, c0;

    pmac_link_if link();
    pmac_host pmac_host_i (.clock(clock), .resetn(resetn), .link(link),
        .req_valid(req_valid), .req_write(req_write), .req_code(req_code),
        .req_data(req_data), .req_ready(req_ready), .done(done),
        .rdata(rdata), .nack(nack), .refused(refused));
    pmac_device pmac_device_i (.clock(clock), .resetn(resetn), .link(link),
        .status(status), .adc_done(adc_done), .adc_start(adc_start),
        .cycle_done(cycle_done), .monitor_running(monitor_running),
        .sampling_mode_select(mode_sel), .voltage_source_select(src_sel),
        .voltage_span_select(span_sel), .avg_code(avg_code),
        .pin_one_in(pin_one_in), .pin_one_out(pin_one_out),
        .pin_one_oe(pin_one_oe));
    pmac_link_props pmac_link_props_i (.clock(clock), .resetn(resetn),
        .cmd_valid(link.cmd_valid), .cmd_write(link.cmd_write),
        .cmd_code(link.cmd_code), .cmd_data(link.cmd_data),
        .rsp_valid(link.rsp_valid), .rsp_nack(link.rsp_nack),
        .rsp_data(link.rsp_data));

    initial begin
        forever #2 clock = ~clock;
    end

    // The converter answers every sample request one cycle later.
    always @(posedge clock) begin
        adc_done <= adc_start;
        if (adc_start === 1'b1) starts++;
        if (cycle_done === 1'b1) cycles++;
        ticks++;
        if (ticks == 30000) begin
            errors++;
            finish_test();
        end
    end

    task automatic chk16(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk16(what, {15'h0000, exp}, {15'h0000, got});
    endtask

    task automatic req(input logic w, input logic [7:0] c,
            input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_code <= c;
        req_data <= d;
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk1("done", 1'b1, done);
    endtask

    task automatic drive_status(input logic [15:0] v);
        @(posedge clock);
        status <= v;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic wait_stop();
        int n;
        for (n = 0; n < 600 && monitor_running !== 1'b0; n++) begin
            @(posedge clock);
            #1;
        end
        // The cycle done pulse is counted one edge after go clears.
        @(posedge clock);
        #1;
        chk1("running", 1'b0, monitor_running);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (20) @(posedge clock);
        chk16("idle_samples", 16'h0000, 16'(starts));
        req(1'b0, PMAC_CMD_RUN, 16'h0000);
        chk16("run_reset", 16'h0000, rdata);
        req(1'b0, PMAC_CMD_SETUP, 16'h0000);
        chk16("setup_reset", 16'h002c, rdata);
        req(1'b0, PMAC_CMD_ALERT, 16'h0000);
        chk16("alert_reset", 16'h0000, rdata);
        chk1("alert_nack", 1'b0, nack);
        req(1'b0, 8'h99, 16'h0000);
        chk1("unknown_nack", 1'b1, nack);
        chk1("mode_reset", 1'b0, mode_sel);
        chk1("span_reset", 1'b1, span_sel);
        $display("test reset done");
        req(1'b1, PMAC_CMD_SETUP, 16'h00e7);
        req(1'b0, PMAC_CMD_SETUP, 16'h0000);
        chk16("setup_rb", 16'h00ef, rdata);
        chk1("mode", 1'b1, mode_sel);
        chk1("src", 1'b1, src_sel);
        chk1("span", 1'b1, span_sel);
        req(1'b1, PMAC_CMD_SETUP, 16'h001a);
        chk1("src_in", 1'b0, src_sel);
        chk1("span_low", 1'b0, span_sel);
        for (int c = 0; c < 8; c++) begin
            req(1'b1, PMAC_CMD_SETUP, 16'h0028 | 16'(c));
            chk16("avg", 16'(c), {13'h0000, avg_code});
            s0 = starts;
            c0 = cycles;
            req(1'b1, PMAC_CMD_RUN, 16'h00ff);
            wait_stop();
            chk16("samples", 16'(1 << c), 16'(starts - s0));
            chk16("cycles", 16'h0001, 16'(cycles - c0));
            req(1'b0, PMAC_CMD_RUN, 16'h0000);
            chk16("go_clear", 16'h0000, rdata);
        end
        $display("test single shot done");
        req(1'b1, PMAC_CMD_SETUP, 16'h00a8);
        s0 = starts;
        req(1'b1, PMAC_CMD_RUN, 16'h0001);
        repeat (40) @(posedge clock);
        chk1("continuing", 1'b1, (starts - s0) > 4);
        req(1'b0, PMAC_CMD_RUN, 16'h0000);
        chk16("go_held", 16'h0001, rdata);
        req(1'b1, PMAC_CMD_SETUP, 16'h0028);
        chk1("refused", 1'b1, refused);
        req(1'b1, PMAC_CMD_RUN, 16'h00fe);
        repeat (5) @(posedge clock);
        s0 = starts;
        repeat (20) @(posedge clock);
        chk16("stopped", 16'h0000, 16'(starts - s0));
        req(1'b0, PMAC_CMD_RUN, 16'h0000);
        chk16("run_rsvd", 16'h0000, rdata);
        req(1'b1, PMAC_CMD_SETUP, 16'h0028);
        chk1("accepted", 1'b0, refused);
        $display("test continuous done");
        chk1("pin_driven", 1'b1, pin_one_oe);
        for (int b = 6; b < 16; b++) begin
            req(1'b1, PMAC_CMD_ALERT, 16'(1 << b));
            drive_status(16'(1 << b));
            chk1("alert_on", 1'b0, pin_one_out);
            drive_status(16'hfff0 & ~16'(1 << b));
            chk1("alert_off", 1'b1, pin_one_out);
        end
        drive_status(16'h0000);
        req(1'b1, PMAC_CMD_ALERT, 16'hc008);
        chk1("pol_idle", 1'b0, pin_one_out);
        drive_status(16'h4000);
        chk1("pol_on", 1'b1, pin_one_out);
        drive_status(16'hc000);
        chk1("pol_both", 1'b1, pin_one_out);
        req(1'b1, PMAC_CMD_ALERT, 16'h0002);
        chk1("gpo_low", 1'b0, pin_one_out);
        req(1'b1, PMAC_CMD_ALERT, 16'hc00c);
        repeat (2) @(posedge clock);
        #1;
        chk1("pin_input", 1'b0, pin_one_oe);
        s0 = starts;
        @(posedge clock);
        pin_one_in <= 1'b1;
        repeat (8) @(posedge clock);
        pin_one_in <= 1'b0;
        repeat (20) @(posedge clock);
        chk16("convert", 16'h0001, 16'(starts - s0));
        wait_stop();
        $display("test alert done");
        finish_test();
    end
endmodule
`default_nettype wire
